// [common/calm_pkg.sv]
// Constants for the calendar alarm compare block.
// Assumes an 8-bit register port with byte offsets as listed below.
`default_nettype none
package calm_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] CALM_OFF_CTRL1 = 8'h00;
   localparam logic [7:0] CALM_OFF_CTRL2 = 8'h01;
   localparam logic [7:0] CALM_OFF_SEC   = 8'h0a;
   localparam logic [7:0] CALM_OFF_MIN   = 8'h0b;
   localparam logic [7:0] CALM_OFF_HOUR  = 8'h0c;
   localparam logic [7:0] CALM_OFF_DATE  = 8'h0d;
   localparam logic [7:0] CALM_OFF_DOW   = 8'h0e;
   // ==========================================================
   // Field positions
   localparam int CALM_BIT_DIS      = 7;
   localparam int CALM_BIT_MERIDIAN = 5;
   localparam int CALM_BIT_FMT12    = 2;
   localparam int CALM_BIT_FLAG     = 4;
   // Index of each field in the disable vector
   localparam int CALM_F_SEC  = 0;
   localparam int CALM_F_MIN  = 1;
   localparam int CALM_F_HOUR = 2;
   localparam int CALM_F_DATE = 3;
   localparam int CALM_F_DOW  = 4;
   localparam int CALM_NFIELD = 5;
   // ==========================================================
   // Values after reset
   localparam logic [4:0] CALM_DIS_RST   = 5'h1f;
   localparam logic       CALM_FMT12_RST = 1'b0;
   localparam logic       CALM_FLAG_RST  = 1'b0;
endpackage : calm_pkg
`default_nettype wire

// [common/calm_cmp_if.sv]
// Carrier between the alarm register file and the comparator.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface calm_cmp_if;
   logic [6:0] tgt_sec;
   logic [6:0] tgt_min;
   logic [5:0] tgt_hour;
   logic [5:0] tgt_date;
   logic [2:0] tgt_dow;
   logic [4:0] dis;
   logic       fmt12;
   logic [6:0] now_sec;
   logic [6:0] now_min;
   logic [5:0] now_hour;
   logic [5:0] now_date;
   logic [2:0] now_dow;
   logic       match;
   modport regs (output tgt_sec, tgt_min, tgt_hour, tgt_date, tgt_dow, dis, fmt12,
                 output now_sec, now_min, now_hour, now_date, now_dow, input match);
   modport cmp  (input tgt_sec, tgt_min, tgt_hour, tgt_date, tgt_dow, dis, fmt12,
                 input now_sec, now_min, now_hour, now_date, now_dow, output match);
endinterface : calm_cmp_if
`default_nettype wire

// [verilog/calm_compare.sv]
// Combinational field comparator for the alarm.
// Assumes targets and running time share the same BCD layout.
`timescale 1ns/1ps
`default_nettype none
module calm_compare
   import calm_pkg::*;
(
   calm_cmp_if.cmp c   // Targets, disables, running time, match
);
   logic [CALM_NFIELD-1:0] eq;

   // ==========================================================
   // Hour key per format
   function automatic logic [5:0] calm_hour_key(input logic fmt12, input logic [5:0] h);
      if (fmt12)
      begin
         // Meridian, one tens bit, units
         calm_hour_key = {h[CALM_BIT_MERIDIAN], h[4], h[3:0]};
      end
      else
      begin
         calm_hour_key = {h[5:4], h[3:0]};
      end
   endfunction : calm_hour_key

   assign eq[CALM_F_SEC]  = (c.tgt_sec == c.now_sec);
   assign eq[CALM_F_MIN]  = (c.tgt_min == c.now_min);
   assign eq[CALM_F_HOUR] = (calm_hour_key(c.fmt12, c.tgt_hour)
                             == calm_hour_key(c.fmt12, c.now_hour));
   assign eq[CALM_F_DATE] = (c.tgt_date == c.now_date);
   assign eq[CALM_F_DOW]  = (c.tgt_dow == c.now_dow);

   // Disabled fields drop out; nothing enabled means no alarm at all
   assign c.match = (&(eq | c.dis)) && (c.dis != CALM_DIS_RST);
endmodule : calm_compare
`default_nettype wire

// [verilog/calm_top.sv]
// Alarm compare unit of a real time clock, register port and flag.
// Assumes tick_1hz is a one-cycle pulse on clk_sys, issued after the
// time counters have taken their new value.
`timescale 1ns/1ps
`default_nettype none
module calm_top
   import calm_pkg::*;
(
   input  wire logic       clk_sys,      // 250 MHz system clock
   input  wire logic       srst,         // Synchronous reset, active high
   input  wire logic [7:0] reg_addr,     // Register offset
   input  wire logic       reg_wr,       // Write strobe, one cycle
   input  wire logic [7:0] reg_wdata,    // Write data
   input  wire logic       reg_rd,       // Read strobe, one cycle
   output logic      [7:0] reg_rdata,    // Read data, cycle after reg_rd
   input  wire logic       tick_1hz,     // Time update pulse
   input  wire logic [6:0] time_sec,     // Running seconds, BCD
   input  wire logic [6:0] time_min,     // Running minutes, BCD
   input  wire logic [5:0] time_hour,    // Running hours, BCD
   input  wire logic [5:0] time_date,    // Running day of month, BCD
   input  wire logic [2:0] time_dow,     // Running weekday 0 to 6
   output logic            hour_fmt12,   // Hour format select to counters
   output logic            alarm_match_flag  // Sticky alarm flag
);
   logic [6:0]             sec_q;
   logic [6:0]             min_q;
   logic [5:0]             hour_q;
   logic [5:0]             date_q;
   logic [2:0]             dow_q;
   logic [CALM_NFIELD-1:0] dis_q;
   logic                   fmt12_q;
   logic                   flag_q;
   logic                   prev_q;
   logic [7:0]             rdata_q;
   logic [7:0]             rdata_d;
   logic                   set_ev;
   logic                   clr_ev;

   calm_cmp_if cif ();

   calm_compare u_cmp (
      .c (cif.cmp)
   );

   assign cif.tgt_sec  = sec_q;
   assign cif.tgt_min  = min_q;
   assign cif.tgt_hour = hour_q;
   assign cif.tgt_date = date_q;
   assign cif.tgt_dow  = dow_q;
   assign cif.dis      = dis_q;
   assign cif.fmt12    = fmt12_q;
   assign cif.now_sec  = time_sec;
   assign cif.now_min  = time_min;
   assign cif.now_hour = time_hour;
   assign cif.now_date = time_date;
   assign cif.now_dow  = time_dow;

   // ==========================================================
   // Target values
   // No reset on purpose: contents survive later resets
   always_ff @(posedge clk_sys)
   begin
      if (reg_wr)
      begin
         if (reg_addr == CALM_OFF_SEC)
         begin
            sec_q <= reg_wdata[6:0];
         end
         else if (reg_addr == CALM_OFF_MIN)
         begin
            min_q <= reg_wdata[6:0];
         end
         else if (reg_addr == CALM_OFF_HOUR)
         begin
            hour_q <= reg_wdata[5:0];
         end
         else if (reg_addr == CALM_OFF_DATE)
         begin
            date_q <= reg_wdata[5:0];
         end
         else if (reg_addr == CALM_OFF_DOW)
         begin
            dow_q <= reg_wdata[2:0];
         end
      end
   end

   // ==========================================================
   // Match disables and format
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         dis_q   <= CALM_DIS_RST;
         fmt12_q <= CALM_FMT12_RST;
      end
      else if (reg_wr)
      begin
         if (reg_addr == CALM_OFF_CTRL1)
         begin
            fmt12_q <= reg_wdata[CALM_BIT_FMT12];
         end
         else if (reg_addr == CALM_OFF_SEC)
         begin
            dis_q[CALM_F_SEC] <= reg_wdata[CALM_BIT_DIS];
         end
         else if (reg_addr == CALM_OFF_MIN)
         begin
            dis_q[CALM_F_MIN] <= reg_wdata[CALM_BIT_DIS];
         end
         else if (reg_addr == CALM_OFF_HOUR)
         begin
            dis_q[CALM_F_HOUR] <= reg_wdata[CALM_BIT_DIS];
         end
         else if (reg_addr == CALM_OFF_DATE)
         begin
            dis_q[CALM_F_DATE] <= reg_wdata[CALM_BIT_DIS];
         end
         else if (reg_addr == CALM_OFF_DOW)
         begin
            dis_q[CALM_F_DOW] <= reg_wdata[CALM_BIT_DIS];
         end
      end
   end

   // ==========================================================
   // Alarm flag
   // Edge of the match at each tick; a held match stays quiet
   assign set_ev = tick_1hz && cif.match && !prev_q;
   assign clr_ev = reg_wr && (reg_addr == CALM_OFF_CTRL2) && !reg_wdata[CALM_BIT_FLAG];

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         prev_q <= 1'b0;
      end
      else if (tick_1hz)
      begin
         prev_q <= cif.match;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         flag_q <= CALM_FLAG_RST;
      end
      else if (set_ev)
      begin
         // Set beats a clear landing in the same cycle
         flag_q <= 1'b1;
      end
      else if (clr_ev)
      begin
         flag_q <= 1'b0;
      end
   end

   // ==========================================================
   // Read path
   always_comb
   begin
      rdata_d = 8'h00;
      if (reg_addr == CALM_OFF_CTRL1)
      begin
         rdata_d[CALM_BIT_FMT12] = fmt12_q;
      end
      else if (reg_addr == CALM_OFF_CTRL2)
      begin
         rdata_d[CALM_BIT_FLAG] = flag_q;
      end
      else if (reg_addr == CALM_OFF_SEC)
      begin
         rdata_d = {dis_q[CALM_F_SEC], sec_q};
      end
      else if (reg_addr == CALM_OFF_MIN)
      begin
         rdata_d = {dis_q[CALM_F_MIN], min_q};
      end
      else if (reg_addr == CALM_OFF_HOUR)
      begin
         rdata_d = {dis_q[CALM_F_HOUR], 1'b0, hour_q};
      end
      else if (reg_addr == CALM_OFF_DATE)
      begin
         rdata_d = {dis_q[CALM_F_DATE], 1'b0, date_q};
      end
      else if (reg_addr == CALM_OFF_DOW)
      begin
         rdata_d = {dis_q[CALM_F_DOW], 4'h0, dow_q};
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         rdata_q <= 8'h00;
      end
      else if (reg_rd)
      begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata        = rdata_q;
   assign hour_fmt12       = fmt12_q;
   assign alarm_match_flag = flag_q;

   // ==========================================================
   // Checks
   property p_dis_rst;
      @(posedge clk_sys) srst |=> (dis_q == CALM_DIS_RST);
   endproperty
   a_dis_rst: assert property (p_dis_rst)
      else $error("disables not all set after reset");

   property p_dow_unused;
      @(posedge clk_sys) disable iff (srst)
         (reg_rd && reg_addr == CALM_OFF_DOW) |=> (reg_rdata[6:3] == 4'h0);
   endproperty
   a_dow_unused: assert property (p_dow_unused)
      else $error("weekday unused bits not zero");

   property p_set_new;
      @(posedge clk_sys) disable iff (srst)
         (tick_1hz && cif.match && !prev_q) |=> flag_q;
   endproperty
   a_set_new: assert property (p_set_new)
      else $error("flag not set on new match");

   property p_sticky;
      @(posedge clk_sys) disable iff (srst)
         (flag_q && !clr_ev) |=> flag_q;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("flag dropped without clear");

   property p_no_persist;
      @(posedge clk_sys) disable iff (srst)
         (!flag_q && (!tick_1hz || prev_q)) |=> !flag_q;
   endproperty
   a_no_persist: assert property (p_no_persist)
      else $error("flag raised without new match");

   property p_clear;
      @(posedge clk_sys) disable iff (srst)
         (clr_ev && !set_ev) |=> !flag_q ##1 (!flag_q || $past(set_ev));
   endproperty
   a_clear: assert property (p_clear)
      else $error("zero write did not clear flag");

   property p_rise_tick;
      @(posedge clk_sys) disable iff (srst)
         $rose(flag_q) |-> $past(tick_1hz);
   endproperty
   a_rise_tick: assert property (p_rise_tick)
      else $error("flag rose without tick");

   property p_all_off;
      @(posedge clk_sys) disable iff (srst)
         (dis_q == CALM_DIS_RST) |=> !$rose(flag_q);
   endproperty
   a_all_off: assert property (p_all_off)
      else $error("match with every field disabled");

   c_set:   cover property (@(posedge clk_sys) disable iff (srst) $rose(flag_q));
   c_clear: cover property (@(posedge clk_sys) disable iff (srst) $fell(flag_q));
   c_race:  cover property (@(posedge clk_sys) disable iff (srst) set_ev && clr_ev);
   c_fmt12: cover property (@(posedge clk_sys) disable iff (srst) fmt12_q && set_ev);
endmodule : calm_top
`default_nettype wire

// [bench/calm_host_model.sv]
// Host model: drives the register port of the alarm compare block.
// Assumes one clock; strobes last one cycle, the bus is released after.
`timescale 1ns/1ps
`default_nettype none
module calm_host_model
(
   input  wire logic       clk_sys,    // System clock
   output logic      [7:0] reg_addr,   // Register offset
   output logic            reg_wr,     // Write strobe
   output logic      [7:0] reg_wdata,  // Write data
   output logic            reg_rd,     // Read strobe
   input  wire logic [7:0] reg_rdata   // Read data
);
   initial
   begin
      reg_addr  <= 8'h00;
      reg_wr    <= 1'b0;
      reg_wdata <= 8'h00;
      reg_rd    <= 1'b0;
   end
   // Released lines show the inverse so stale values cannot pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      @(posedge clk_sys);
      d = reg_rdata;
   endtask : rd
endmodule : calm_host_model
`default_nettype wire

// [bench/calm_top_tb.sv]
// Self-checking bench for the alarm compare block.
// Assumes the host model drives the register port; the bench drives time.
`timescale 1ns/1ps
`default_nettype none
module calm_top_tb;
   import calm_pkg::*;
   typedef struct { logic [7:0] a; logic [7:0] w; logic [7:0] r; } calm_row_t;
   logic       clk_sys = 1'b0;
   logic       srst    = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
   logic       reg_wr, reg_rd, hour_fmt12, alarm_match_flag;
   logic       tick_1hz = 1'b0;
   logic [6:0] time_sec = 7'h00, time_min = 7'h00;
   logic [5:0] time_hour = 6'h00, time_date = 6'h01;
   logic [2:0] time_dow = 3'h0;
   int         mismatches = 0, samples_checked = 0;
   calm_row_t  rows[7] = '{'{CALM_OFF_SEC, 8'hff, 8'hff}, '{CALM_OFF_MIN, 8'h59, 8'h59},
      '{CALM_OFF_HOUR, 8'hff, 8'hbf}, '{CALM_OFF_DATE, 8'hff, 8'hbf},
      '{CALM_OFF_DOW, 8'hff, 8'h87}, '{CALM_OFF_CTRL2, 8'hff, 8'h00},
      '{8'h20, 8'haa, 8'h00}};
   always #2 clk_sys = ~clk_sys;
   calm_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   calm_top DUT (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tick_1hz(tick_1hz), .time_sec(time_sec), .time_min(time_min),
      .time_hour(time_hour), .time_date(time_date), .time_dow(time_dow),
      .hour_fmt12(hour_fmt12), .alarm_match_flag(alarm_match_flag));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   // Flag is sampled one edge after the tick edge
   task automatic tick(input logic [7:0] s, m, h, d, w);
      @(posedge clk_sys);
      time_sec  <= s[6:0];
      time_min  <= m[6:0];
      time_hour <= h[5:0];
      time_date <= d[5:0];
      time_dow  <= w[2:0];
      tick_1hz  <= 1'b1;
      @(posedge clk_sys);
      tick_1hz  <= 1'b0;
      @(posedge clk_sys);
   endtask : tick
   // Zero in the flag position clears it, ones in the other CTRL2 bits have no effect
   task automatic clear_flag;
      host.wr(CALM_OFF_CTRL2, ~(8'h01 << CALM_BIT_FLAG));
   endtask : clear_flag
   // One enabled field: miss, then hit, then clear and disable it again
   task automatic field_case(input logic [7:0] a, t, s, m, h, d, w);
      host.wr(a, t);
      tick(~s, ~m, ~h, ~d, ~w);
      chk("flag miss", 8'h00, {7'h0, alarm_match_flag});
      tick(s, m, h, d, w);
      chk("flag hit", 8'h01, {7'h0, alarm_match_flag});
      clear_flag();
      host.wr(a, t | 8'h80);
   endtask : field_case
   task automatic do_reset;
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (12) @(posedge clk_sys);
      srst <= 1'b0;
   endtask : do_reset
   initial
   begin
      #40000;
      mismatches++;
      close_out();
   end
   initial
   begin
      do_reset();
      host.rd(CALM_OFF_HOUR, rv);
      chk("hour reset", 8'h80, rv & 8'hc0);
      chk("flag reset", 8'h00, {7'h0, alarm_match_flag});
      foreach (rows[i])
      begin
         host.wr(rows[i].a, rows[i].w);
         host.rd(rows[i].a, rv);
         chk("readback", rows[i].r, rv);
      end
      $display("register rows done");
      for (int i = 0; i < 5; i++)
         host.wr(CALM_OFF_SEC + 8'(i), 8'h80);
      host.wr(CALM_OFF_HOUR, 8'h15);
      tick(8'h00, 8'h00, 8'h15, 8'h01, 8'h0);
      chk("flag set", 8'h01, {7'h0, alarm_match_flag});
      host.wr(CALM_OFF_CTRL2, 8'hff);
      tick(8'h01, 8'h00, 8'h15, 8'h01, 8'h0);
      chk("flag sticky", 8'h01, {7'h0, alarm_match_flag});
      clear_flag();
      host.rd(CALM_OFF_CTRL2, rv);
      chk("flag cleared", 8'h00, rv);
      tick(8'h02, 8'h00, 8'h15, 8'h01, 8'h0);
      chk("flag persist", 8'h00, {7'h0, alarm_match_flag});
      tick(8'h00, 8'h00, 8'h16, 8'h01, 8'h0);
      @(posedge clk_sys);
      time_hour <= 6'h15;
      repeat (4) @(posedge clk_sys);
      chk("flag no tick", 8'h00, {7'h0, alarm_match_flag});
      tick(8'h00, 8'h00, 8'h15, 8'h01, 8'h0);
      chk("flag rematch", 8'h01, {7'h0, alarm_match_flag});
      $display("sticky flag test done");
      do_reset();
      host.rd(CALM_OFF_HOUR, rv);
      chk("hour kept", 8'h95, rv);
      tick(8'h00, 8'h00, 8'h16, 8'h01, 8'h0);
      tick(8'h00, 8'h00, 8'h15, 8'h01, 8'h0);
      chk("all disabled", 8'h00, {7'h0, alarm_match_flag});
      $display("reset test done");
      host.wr(CALM_OFF_CTRL1, 8'h04);
      @(posedge clk_sys);
      chk("fmt12", 8'h01, {7'h0, hour_fmt12});
      field_case(CALM_OFF_HOUR, 8'h32, 8'h00, 8'h00, 8'h32, 8'h01, 8'h0);
      host.wr(CALM_OFF_CTRL1, 8'h00);
      field_case(CALM_OFF_HOUR, 8'h23, 8'h00, 8'h00, 8'h23, 8'h01, 8'h0);
      field_case(CALM_OFF_DATE, 8'h31, 8'h00, 8'h00, 8'h00, 8'h31, 8'h0);
      field_case(CALM_OFF_DOW, 8'h06, 8'h00, 8'h00, 8'h00, 8'h01, 8'h6);
      field_case(CALM_OFF_SEC, 8'h59, 8'h59, 8'h00, 8'h00, 8'h01, 8'h0);
      field_case(CALM_OFF_MIN, 8'h45, 8'h00, 8'h45, 8'h00, 8'h01, 8'h0);
      $display("field tests done");
      close_out();
   end
endmodule : calm_top_tb
`default_nettype wire
